// [hw/dbc_pkg.sv]
package dbc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] DBC_OFS_CURRENT = 4'h0;
    localparam logic [3:0] DBC_OFS_STATUS = 4'h4;
    localparam logic [3:0] DBC_OFS_MASK = 4'h8;
    localparam logic [3:0] DBC_OFS_LIVE = 4'hc;

    // Current register fields
    localparam int DBC_CUR_A_LSB = 0;
    localparam int DBC_CUR_B_LSB = 4;
    localparam logic [3:0] DBC_CUR_RESET = 4'h0;
    localparam logic [3:0] DBC_CUR_FULL = 4'hf;
    localparam logic [3:0] DBC_CUR_OFF = 4'h0;

    // Status and mask bits
    localparam int DBC_ST_OVERCURRENT = 0;
    localparam int DBC_ST_OPEN_A = 1;
    localparam int DBC_ST_OPEN_B = 2;
    localparam logic [2:0] DBC_ST_RESET = 3'h0;
    localparam logic [2:0] DBC_MASK_RESET = 3'h0;

    // Live register fields
    localparam int DBC_LIVE_PHASE_A_LSB = 0;
    localparam int DBC_LIVE_PHASE_B_LSB = 3;
    localparam int DBC_LIVE_OPEN_LSB = 6;
    localparam int DBC_LIVE_POL_LSB = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DBC_CLK_PERIOD_NS = 10;
    localparam int DBC_BLANK0_NS = 600;
    localparam int DBC_BLANK1_NS = 900;
    localparam int DBC_BLANK2_NS = 1200;
    localparam int DBC_BLANK3_NS = 1500;
    localparam int DBC_BLANK0_CYC =
        (DBC_BLANK0_NS + DBC_CLK_PERIOD_NS - 1) / DBC_CLK_PERIOD_NS;
    localparam int DBC_BLANK1_CYC =
        (DBC_BLANK1_NS + DBC_CLK_PERIOD_NS - 1) / DBC_CLK_PERIOD_NS;
    localparam int DBC_BLANK2_CYC =
        (DBC_BLANK2_NS + DBC_CLK_PERIOD_NS - 1) / DBC_CLK_PERIOD_NS;
    localparam int DBC_BLANK3_CYC =
        (DBC_BLANK3_NS + DBC_CLK_PERIOD_NS - 1) / DBC_CLK_PERIOD_NS;
    localparam logic [4:0] DBC_OPEN_LOAD_LIMIT = 5'd14;

    // ------------------------------------------------------------
    // Chopper phases
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        DBC_PH_ON = 3'b001,
        DBC_PH_FAST = 3'b010,
        DBC_PH_SLOW = 3'b100
    } dbc_phase_e;

endpackage

// [hw/dbc_chopper.sv]
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - Code 1111 selects full-scale trip level
// - High-side comparator trip flags overcurrent
// - Phases run on, fast decay, slow decay
// - Bridge A starts rising, B falling edge
// - Fast decay: uppers off, opposite lower on
// - Slow decay: both lowers on, uppers off
// - Polarity change restarts cycle at on
// - Longer on phase shortens fast decay
// - External oscillator clock starts each chopper cycle; blanking and phase counts run on CLK_SYS
// - Overcurrent detection ignored during blank time
// - Blanking masks chopper comparators after switching
// - Mixed decay enable inputs are active low
// - Open load after 15 cycles without switch-off
module dbc_chopper
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt
    output logic IRQ,
    // Chopper oscillator
    input wire logic OSC_CLK,
    // Controller inputs
    input wire logic BRIDGE_A_POLARITY,
    input wire logic BRIDGE_B_POLARITY,
    input wire logic BRIDGE_A_MIXED_DECAY_N,
    input wire logic BRIDGE_B_MIXED_DECAY_N,
    input wire logic BLANK_SELECT_LSB,
    input wire logic BLANK_SELECT_MSB,
    // Comparators
    input wire logic BRIDGE_A_SENSE_INPUT,
    input wire logic BRIDGE_B_SENSE_INPUT,
    input wire logic HIGH_SIDE_THRESHOLD_NODE,
    // Trip level codes to the sense DACs
    output logic [3:0] BRIDGE_A_TRIP_CODE,
    output logic [3:0] BRIDGE_B_TRIP_CODE,
    // Gate drives, index 0 is side 1 of the bridge
    output logic [1:0] BRIDGE_A_HIGH_GATE,
    output logic [1:0] BRIDGE_A_LOW_GATE,
    output logic [1:0] BRIDGE_B_HIGH_GATE,
    output logic [1:0] BRIDGE_B_LOW_GATE
);
    import dbc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic osc;
        logic [1:0] pol;
        dbc_phase_e [1:0] phase;
        logic [1:0][7:0] blank;
        logic [1:0][15:0] on_cnt;
        logic [1:0][15:0] per_cnt;
        logic [1:0][15:0] period;
        logic [1:0][15:0] fast_cnt;
        logic [1:0] tripped;
        logic [1:0][4:0] ol_cnt;
        logic [1:0][3:0] cur;
        logic [2:0] status;
        logic [2:0] mask;
        logic wr_pend;
        logic [3:0] wr_ofs;
        logic [31:0] rdata;
    } dbc_state_s;

    dbc_state_s st_r;
    dbc_state_s st_nxt;

    logic [1:0] start;
    logic [1:0] pol_in;
    logic [1:0] md_n;
    logic [1:0] sense;
    logic [7:0] blank_len;
    logic any_blank;
    logic oc_evt;
    logic [1:0] ol_evt;
    logic acc;
    logic [1:0][1:0] hi_g;
    logic [1:0][1:0] lo_g;

    assign pol_in = {BRIDGE_B_POLARITY, BRIDGE_A_POLARITY};
    assign md_n = {BRIDGE_B_MIXED_DECAY_N, BRIDGE_A_MIXED_DECAY_N};
    assign sense = {BRIDGE_B_SENSE_INPUT, BRIDGE_A_SENSE_INPUT};
    // Oscillator edges start each chopper cycle; blanking and phase counts use CLK_SYS
    assign start[0] = OSC_CLK & ~st_r.osc;
    assign start[1] = ~OSC_CLK & st_r.osc;
    assign any_blank = (st_r.blank[0] != 8'h00) || (st_r.blank[1] != 8'h00);
    // Spikes right after switching must not read as a short
    assign oc_evt = HIGH_SIDE_THRESHOLD_NODE & ~any_blank;
    assign acc = HSEL & HTRANS[1] & HREADY;

    always_comb
    begin
        unique case ({BLANK_SELECT_MSB, BLANK_SELECT_LSB})
            2'b00: blank_len = 8'(DBC_BLANK0_CYC);
            2'b01: blank_len = 8'(DBC_BLANK1_CYC);
            2'b10: blank_len = 8'(DBC_BLANK2_CYC);
            2'b11: blank_len = 8'(DBC_BLANK3_CYC);
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        ol_evt = 2'b00;
        st_nxt.osc = OSC_CLK;
        st_nxt.pol = pol_in;
        for (int b = 0; b < 2; b++)
        begin
            if (st_r.blank[b] != 8'h00)
                st_nxt.blank[b] = st_r.blank[b] - 8'h01;
            if (st_r.per_cnt[b] != 16'hffff)
                st_nxt.per_cnt[b] = st_r.per_cnt[b] + 16'h0001;
            if (start[b])
            begin
                st_nxt.period[b] = st_r.per_cnt[b];
                st_nxt.per_cnt[b] = 16'h0000;
            end
            if (st_r.cur[b] == DBC_CUR_OFF)
            begin
                // Zero current parks the bridge in slow decay
                st_nxt.phase[b] = DBC_PH_SLOW;
                st_nxt.ol_cnt[b] = 5'h00;
                st_nxt.tripped[b] = 1'b0;
            end
            else if (start[b] || (pol_in[b] != st_r.pol[b]))
            begin
                if (start[b])
                begin
                    if (!st_r.tripped[b] && st_r.ol_cnt[b] != 5'h1f)
                        st_nxt.ol_cnt[b] = st_r.ol_cnt[b] + 5'h01;
                    if (!st_r.tripped[b] &&
                        st_r.ol_cnt[b] == DBC_OPEN_LOAD_LIMIT)
                        ol_evt[b] = 1'b1;
                    st_nxt.tripped[b] = 1'b0;
                end
                st_nxt.phase[b] = DBC_PH_ON;
                st_nxt.on_cnt[b] = 16'h0000;
                st_nxt.blank[b] = blank_len;
            end
            else
            begin
                unique case (st_r.phase[b])
                    DBC_PH_ON:
                    begin
                        st_nxt.on_cnt[b] = st_r.on_cnt[b] + 16'h0001;
                        // Comparator is masked while blanking runs
                        if (st_r.blank[b] == 8'h00 && sense[b])
                        begin
                            st_nxt.tripped[b] = 1'b1;
                            st_nxt.ol_cnt[b] = 5'h00;
                            st_nxt.blank[b] = blank_len;
                            if (!md_n[b])
                            begin
                                st_nxt.phase[b] = DBC_PH_FAST;
                                if (st_r.period[b] > st_r.on_cnt[b])
                                    st_nxt.fast_cnt[b] = 16'((st_r.period[b]
                                        - st_r.on_cnt[b]) >> 1);
                                else
                                    st_nxt.fast_cnt[b] = 16'h0000;
                            end
                            else
                                st_nxt.phase[b] = DBC_PH_SLOW;
                        end
                    end
                    DBC_PH_FAST:
                    begin
                        if (st_r.fast_cnt[b] == 16'h0000)
                        begin
                            st_nxt.phase[b] = DBC_PH_SLOW;
                            st_nxt.blank[b] = blank_len;
                        end
                        else
                            st_nxt.fast_cnt[b] = st_r.fast_cnt[b] - 16'h0001;
                    end
                    DBC_PH_SLOW:
                        st_nxt.phase[b] = DBC_PH_SLOW;
                    default:
                        st_nxt.phase[b] = DBC_PH_SLOW;
                endcase
            end
        end

        // Bus: writes land in the data phase
        st_nxt.wr_pend = acc & HWRITE;
        if (acc)
            st_nxt.wr_ofs = HADDR[3:0];
        if (st_r.wr_pend)
        begin
            unique case (st_r.wr_ofs)
                DBC_OFS_CURRENT:
                begin
                    st_nxt.cur[0] = HWDATA[DBC_CUR_A_LSB +: 4];
                    st_nxt.cur[1] = HWDATA[DBC_CUR_B_LSB +: 4];
                end
                DBC_OFS_MASK:
                    st_nxt.mask = HWDATA[2:0];
                default:
                    st_nxt.mask = st_r.mask;
            endcase
        end

        // Read data is captured in the address phase
        st_nxt.rdata = 32'h0000_0000;
        if (acc && !HWRITE)
        begin
            unique case (HADDR[3:0])
                DBC_OFS_CURRENT:
                begin
                    st_nxt.rdata[DBC_CUR_A_LSB +: 4] = st_r.cur[0];
                    st_nxt.rdata[DBC_CUR_B_LSB +: 4] = st_r.cur[1];
                end
                DBC_OFS_STATUS:
                    st_nxt.rdata[2:0] = st_r.status;
                DBC_OFS_MASK:
                    st_nxt.rdata[2:0] = st_r.mask;
                DBC_OFS_LIVE:
                begin
                    st_nxt.rdata[DBC_LIVE_PHASE_A_LSB +: 3] = st_r.phase[0];
                    st_nxt.rdata[DBC_LIVE_PHASE_B_LSB +: 3] = st_r.phase[1];
                    st_nxt.rdata[DBC_LIVE_OPEN_LSB] =
                        st_r.ol_cnt[0] > DBC_OPEN_LOAD_LIMIT;
                    st_nxt.rdata[DBC_LIVE_OPEN_LSB + 1] =
                        st_r.ol_cnt[1] > DBC_OPEN_LOAD_LIMIT;
                    st_nxt.rdata[DBC_LIVE_POL_LSB +: 2] = st_r.pol;
                end
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Read clears status; a new event in the same cycle wins
        if (acc && !HWRITE && HADDR[3:0] == DBC_OFS_STATUS)
            st_nxt.status = 3'h0;
        st_nxt.status[DBC_ST_OVERCURRENT] =
            st_nxt.status[DBC_ST_OVERCURRENT] | oc_evt;
        st_nxt.status[DBC_ST_OPEN_A] = st_nxt.status[DBC_ST_OPEN_A] | ol_evt[0];
        st_nxt.status[DBC_ST_OPEN_B] = st_nxt.status[DBC_ST_OPEN_B] | ol_evt[1];
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_r <= '0;
            st_r.phase <= {DBC_PH_SLOW, DBC_PH_SLOW};
            st_r.cur <= {DBC_CUR_RESET, DBC_CUR_RESET};
            st_r.status <= DBC_ST_RESET;
            st_r.mask <= DBC_MASK_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Gates decode registered state only, so no glitch between phases
    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            hi_g[b] = 2'b00;
            lo_g[b] = 2'b00;
            unique case (st_r.phase[b])
                DBC_PH_ON:
                begin
                    hi_g[b][st_r.pol[b]] = 1'b1;
                    lo_g[b][~st_r.pol[b]] = 1'b1;
                end
                DBC_PH_FAST:
                    lo_g[b][st_r.pol[b]] = 1'b1;
                DBC_PH_SLOW:
                    lo_g[b] = 2'b11;
                default:
                    lo_g[b] = 2'b11;
            endcase
        end
    end

    assign BRIDGE_A_HIGH_GATE = hi_g[0];
    assign BRIDGE_A_LOW_GATE = lo_g[0];
    assign BRIDGE_B_HIGH_GATE = hi_g[1];
    assign BRIDGE_B_LOW_GATE = lo_g[1];
    assign BRIDGE_A_TRIP_CODE = st_r.cur[0];
    assign BRIDGE_B_TRIP_CODE = st_r.cur[1];
    assign HRDATA = st_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ = |(st_r.status & st_r.mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_full_scale_code: assert property (
        st_r.wr_pend && st_r.wr_ofs == DBC_OFS_CURRENT &&
        HWDATA[3:0] == DBC_CUR_FULL |=> BRIDGE_A_TRIP_CODE == DBC_CUR_FULL)
        else $error("full-scale code not applied");
    a_overcurrent_flag: assert property (
        HIGH_SIDE_THRESHOLD_NODE && !any_blank
        |=> st_r.status[DBC_ST_OVERCURRENT])
        else $error("overcurrent not flagged");
    a_overcurrent_blank: assert property (
        !st_r.status[DBC_ST_OVERCURRENT] ##1
        st_r.status[DBC_ST_OVERCURRENT]
        |-> $past(HIGH_SIDE_THRESHOLD_NODE) && !$past(any_blank))
        else $error("overcurrent flagged inside blank time");
    a_phase_order: assert property (
        st_r.phase[0] == DBC_PH_ON ##1 st_r.phase[0] == DBC_PH_FAST
        |-> !$past(BRIDGE_A_MIXED_DECAY_N))
        else $error("fast decay without mixed decay");
    a_slow_not_to_fast: assert property (
        st_r.phase[0] == DBC_PH_SLOW |=> st_r.phase[0] != DBC_PH_FAST)
        else $error("slow decay went to fast decay");
    a_start_edges: assert property (
        st_r.cur[1] != DBC_CUR_OFF && start[1] |=> st_r.phase[1] == DBC_PH_ON
        ##0 BRIDGE_B_HIGH_GATE != 2'b00)
        else $error("bridge B did not start on falling edge");
    a_fast_gates: assert property (
        st_r.phase[0] == DBC_PH_FAST |-> BRIDGE_A_HIGH_GATE == 2'b00
        && BRIDGE_A_LOW_GATE == (st_r.pol[0] ? 2'b10 : 2'b01))
        else $error("fast decay gate pattern wrong");
    a_slow_gates: assert property (
        st_r.phase[1] == DBC_PH_SLOW |-> BRIDGE_B_HIGH_GATE == 2'b00
        && BRIDGE_B_LOW_GATE == 2'b11)
        else $error("slow decay gate pattern wrong");
    a_pol_restart: assert property (
        st_r.cur[0] != DBC_CUR_OFF && BRIDGE_A_POLARITY != st_r.pol[0]
        |=> st_r.phase[0] == DBC_PH_ON && st_r.on_cnt[0] == 16'h0000)
        else $error("polarity change did not restart");
    a_blank_mask: assert property (
        st_r.phase[0] == DBC_PH_ON && st_r.blank[0] != 8'h00 && !start[0]
        && BRIDGE_A_POLARITY == st_r.pol[0] && st_r.cur[0] != DBC_CUR_OFF
        |=> st_r.phase[0] == DBC_PH_ON)
        else $error("on phase ended inside blank time");
    a_open_load: assert property (
        ol_evt[0] |=> st_r.status[DBC_ST_OPEN_A]
        && st_r.ol_cnt[0] == DBC_OPEN_LOAD_LIMIT + 5'd1)
        else $error("open load not flagged");
    a_fast_len: assert property (
        st_r.phase[0] == DBC_PH_ON ##1 st_r.phase[0] == DBC_PH_FAST
        |-> st_r.fast_cnt[0] <= ($past(st_r.period[0]) >> 1))
        else $error("fast decay too long");

    c_mixed_cycle: cover property (st_r.phase[0] == DBC_PH_ON
        ##1 st_r.phase[0] == DBC_PH_FAST);
    c_open_load: cover property (ol_evt[0]);
    c_overcurrent: cover property (oc_evt);
    c_irq: cover property ($rose(IRQ));
endmodule

// [bench/dbc_bridge_model.sv]
`timescale 1ns/1ps
module dbc_bridge_model
#(
    parameter int SCALE = 20
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Gate drives
    input wire logic [1:0] high_a,
    input wire logic [1:0] low_a,
    input wire logic [1:0] high_b,
    input wire logic [1:0] low_b,
    // Trip codes and commanded faults
    input wire logic [3:0] code_a,
    input wire logic [3:0] code_b,
    input wire logic open_a,
    input wire logic short_gnd,
    // Comparators
    output logic sense_a,
    output logic sense_b,
    output logic high_side
);
    typedef struct packed
    {
        logic [11:0] cur_a;
        logic [11:0] cur_b;
    } dbc_coil_s;
    dbc_coil_s st_r;
    dbc_coil_s st_nxt;

    // --------
    // Coils
    // --------
    // Fast decay drains four times quicker than slow decay
    function automatic logic [11:0] coil(input logic [11:0] c,
        input logic [1:0] h, input logic [1:0] l);
        if (h != 2'b00)
            return c + 12'h001;
        if (l != 2'b11)
            return (c > 12'h004) ? c - 12'h004 : 12'h000;
        return (c > 12'h000) ? c - 12'h001 : 12'h000;
    endfunction

    always_comb
    begin
        st_nxt.cur_a = open_a ? 12'h000 : coil(st_r.cur_a, high_a, low_a);
        st_nxt.cur_b = coil(st_r.cur_b, high_b, low_b);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // A zero code never trips, so the bridge idles
    assign sense_a = (code_a != 4'h0)
        && (st_r.cur_a >= 12'(code_a) * 12'(SCALE));
    assign sense_b = (code_b != 4'h0)
        && (st_r.cur_b >= 12'(code_b) * 12'(SCALE));
    assign high_side = short_gnd;
endmodule

// [bench/dbc_chopper_bench.sv]
`timescale 1ns/1ps
module dbc_chopper_bench;
    import dbc_pkg::*;
    localparam int SCALE = 20;
    localparam int PER = 1000;
    localparam logic [31:0] A_CUR = 32'(DBC_OFS_CURRENT);
    localparam logic [31:0] A_ST = 32'(DBC_OFS_STATUS);
    localparam logic [31:0] A_MSK = 32'(DBC_OFS_MASK);
    localparam logic [31:0] A_LIVE = 32'(DBC_OFS_LIVE);
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, IRQ;
    logic OSC_CLK = 1'b0;
    logic pol_a = 1'b0, pol_b = 1'b0, md_a_n = 1'b1, md_b_n = 1'b1;
    logic [1:0] bsel = 2'h0;
    logic short_gnd = 1'b0, open_a = 1'b0;
    logic sense_a, sense_b, high_side;
    logic [3:0] code_a, code_b;
    logic [1:0] hg [2];
    logic [1:0] lg [2];
    logic [31:0] rdat;
    int fails = 0, cmp_count = 0, osc_cnt = 0;
    int dly, on_n, f_n, on1, f1;
    int blank_tab [4] = '{DBC_BLANK0_CYC, DBC_BLANK1_CYC,
        DBC_BLANK2_CYC, DBC_BLANK3_CYC};

    always #5 CLK_SYS = ~CLK_SYS;

    // Oscillator held at its 100 kHz ceiling, setting the chopping period
    always @(posedge CLK_SYS)
    begin
        osc_cnt <= (osc_cnt == PER / 2 - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == PER / 2 - 1)
            OSC_CLK <= ~OSC_CLK;
    end

    dbc_chopper dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
        .OSC_CLK(OSC_CLK), .BRIDGE_A_POLARITY(pol_a),
        .BRIDGE_B_POLARITY(pol_b), .BRIDGE_A_MIXED_DECAY_N(md_a_n),
        .BRIDGE_B_MIXED_DECAY_N(md_b_n), .BLANK_SELECT_LSB(bsel[0]),
        .BLANK_SELECT_MSB(bsel[1]), .BRIDGE_A_SENSE_INPUT(sense_a),
        .BRIDGE_B_SENSE_INPUT(sense_b),
        .HIGH_SIDE_THRESHOLD_NODE(high_side),
        .BRIDGE_A_TRIP_CODE(code_a), .BRIDGE_B_TRIP_CODE(code_b),
        .BRIDGE_A_HIGH_GATE(hg[0]), .BRIDGE_A_LOW_GATE(lg[0]),
        .BRIDGE_B_HIGH_GATE(hg[1]), .BRIDGE_B_LOW_GATE(lg[1]));

    dbc_bridge_model #(.SCALE(SCALE)) bridges (.clk(CLK_SYS), .rst(RST),
        .high_a(hg[0]), .low_a(lg[0]), .high_b(hg[1]), .low_b(lg[1]),
        .code_a(code_a), .code_b(code_b), .open_a(open_a),
        .short_gnd(short_gnd), .sense_a(sense_a), .sense_b(sense_b),
        .high_side(high_side));

    // --------
    // Tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (n == 50)
            fails++;
    endtask

    task automatic bus(input logic [31:0] a, input logic w,
        input logic [31:0] d);
        @(posedge CLK_SYS);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        wait_ready();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        rdat = HRDATA;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rdat & m, exp);
    endtask

    // Follows one chopper cycle of a bridge and measures its phases
    task automatic chop(input int b, output int dl, output int on,
        output int fa);
        logic p;
        dl = 0;
        on = 0;
        fa = 0;
        p = b ? pol_b : pol_a;
        if (b == 0)
            @(posedge OSC_CLK);
        else
            @(negedge OSC_CLK);
        while (hg[b] === 2'b00 && dl < 8)
        begin
            @(negedge CLK_SYS);
            dl++;
        end
        check(32'(dl >= 1 && dl <= 4), 32'h1);
        check(32'({hg[b], lg[b]}), p ? 32'h9 : 32'h6);
        while (hg[b] !== 2'b00 && on < 2 * PER)
        begin
            @(negedge CLK_SYS);
            on++;
        end
        while (lg[b] !== 2'b11 && fa < PER)
        begin
            check(32'({hg[b], lg[b]}), p ? 32'h2 : 32'h1);
            @(negedge CLK_SYS);
            fa++;
        end
        check(32'({hg[b], lg[b]}), 32'h3);
    endtask

    // --------
    // Tests
    // --------
    initial
    begin
        repeat (6) @(posedge CLK_SYS);
        RST <= 1'b0;
        check(32'({HRESP, HREADYOUT, IRQ, code_a, code_b, hg[0], lg[0],
            hg[1], lg[1]}), 32'h20033);
        rd_chk(A_CUR, 32'hff, 32'h0);
        rd_chk(A_ST, 32'h7, 32'h0);
        rd_chk(A_MSK, 32'h7, 32'h0);
        rd_chk(A_LIVE, 32'h3ff, 32'h24);
        rd_chk(32'h3, 32'hffffffff, 32'h0);
        bus(A_ST, 1'b1, 32'h7);
        rd_chk(A_ST, 32'h7, 32'h0);
        bus(A_CUR, 1'b1, 32'h22);
        rd_chk(A_CUR, 32'hff, 32'h22);
        check(32'({code_a, code_b}), 32'h22);
        $display("test registers done");
        for (int s = 0; s < 4; s++)
        begin
            @(posedge CLK_SYS);
            bsel <= 2'(s);
            chop(0, dly, on_n, f_n);
            chop(0, dly, on_n, f_n);
            check(32'(on_n >= blank_tab[s] && on_n <= blank_tab[s] + 4),
                32'h1);
            check(32'(f_n), 32'h0);
        end
        @(posedge CLK_SYS);
        bsel <= 2'h0;
        chop(1, dly, on_n, f_n);
        chop(1, dly, on_n, f_n);
        check(32'(on_n >= blank_tab[0] && on_n <= blank_tab[0] + 4),
            32'h1);
        $display("test blanking done");
        @(posedge CLK_SYS);
        md_a_n <= 1'b0;
        md_b_n <= 1'b0;
        chop(0, dly, on1, f1);
        chop(0, dly, on1, f1);
        check(32'(f1 - (PER - on1) / 2 <= 3 && (PER - on1) / 2 - f1 <= 3),
            32'h1);
        bus(A_CUR, 1'b1, 32'h2f);
        chop(0, dly, on_n, f_n);
        chop(0, dly, on_n, f_n);
        check(32'(on_n >= 15 * SCALE && on_n <= 15 * SCALE + 4),
            32'h1);
        check(32'(f_n < f1 && f_n - (PER - on_n) / 2 <= 3
            && (PER - on_n) / 2 - f_n <= 3), 32'h1);
        @(posedge CLK_SYS);
        md_a_n <= 1'b1;
        md_b_n <= 1'b1;
        $display("test mixed decay done");
        repeat (100) @(posedge CLK_SYS);
        pol_a <= 1'b1;
        pol_b <= 1'b1;
        repeat (4) @(negedge CLK_SYS);
        check(32'({hg[0], lg[0], hg[1], lg[1]}), 32'h99);
        $display("test polarity done");
        bus(A_MSK, 1'b1, 32'h1);
        bus(A_ST, 1'b0, 32'h0);
        @(posedge OSC_CLK);
        repeat (2) @(posedge CLK_SYS);
        short_gnd <= 1'b1;
        repeat (30) @(posedge CLK_SYS);
        short_gnd <= 1'b0;
        repeat (3) @(negedge CLK_SYS);
        check(32'(IRQ), 32'h0);
        repeat (150) @(posedge CLK_SYS);
        short_gnd <= 1'b1;
        repeat (3) @(negedge CLK_SYS);
        check(32'(IRQ), 32'h1);
        @(posedge CLK_SYS);
        short_gnd <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        rd_chk(A_ST, 32'h1, 32'h1);
        @(negedge CLK_SYS);
        check(32'(IRQ), 32'h0);
        bus(A_MSK, 1'b1, 32'h0);
        short_gnd <= 1'b1;
        repeat (200) @(posedge CLK_SYS);
        short_gnd <= 1'b0;
        check(32'(IRQ), 32'h0);
        repeat (3) @(posedge CLK_SYS);
        rd_chk(A_ST, 32'h1, 32'h1);
        $display("test overcurrent done");
        bus(A_MSK, 1'b1, 32'h2);
        chop(0, dly, on_n, f_n);
        @(posedge CLK_SYS);
        open_a <= 1'b1;
        repeat (15) @(posedge OSC_CLK);
        repeat (20) @(posedge CLK_SYS);
        rd_chk(A_LIVE, 32'h40, 32'h0);
        @(posedge OSC_CLK);
        repeat (20) @(posedge CLK_SYS);
        rd_chk(A_LIVE, 32'h40, 32'h40);
        check(32'(IRQ), 32'h1);
        rd_chk(A_ST, 32'h6, 32'h2);
        open_a <= 1'b0;
        $display("test open load done");
        give_verdict();
    end

    // Runs of about 30 oscillator periods are expected
    initial
    begin
        #600000;
        fails++;
        give_verdict();
    end
endmodule
